// ### cgc_pkg.sv
`default_nettype none
package cgc_pkg;

    // register indexes as printed; byte address is four times the index
    localparam logic [31:0] CGC_IDX_CHG_CTRL2   = 32'h50001b0a;
    localparam logic [31:0] CGC_IDX_CHG_STATE   = 32'h50001b0c;
    localparam logic [31:0] CGC_IDX_GAUGE_CTRL1 = 32'h50001b40;
    localparam logic [31:0] CGC_IDX_ACC_LOW     = 32'h50001b48;
    localparam logic [31:0] CGC_IDX_ACC_MID     = 32'h50001b4a;
    localparam logic [31:0] CGC_IDX_ACC_HIGH    = 32'h50001b4c;
    localparam logic [31:0] CGC_IDX_ACC_AVG     = 32'h50001b50;

    // only the low address bits are decoded
    localparam int          CGC_DEC_BITS = 12;

    // reset values
    localparam logic [15:0] CGC_RST_CHG_CTRL2   = 16'h0f07;
    localparam logic [15:0] CGC_RST_GAUGE_CTRL1 = 16'hd880;

    // test selector codes
    localparam logic [2:0]  CGC_TEST_NONE       = 3'h0;
    localparam logic [2:0]  CGC_TEST_RESERVED   = 3'h7;

    // accumulator layout and synchroniser width
    localparam int          CGC_ACC_W      = 40;
    localparam int          CGC_WORD_W     = 16;
    localparam int          CGC_HIGH_W     = 8;
    localparam int          CGC_SYNC_W     = 7;

    // register select codes, one-hot apart from the all-zero none code
    typedef enum logic [7:0] {
        CGC_SEL_NONE  = 8'h00,
        CGC_SEL_CTRL2 = 8'h01,
        CGC_SEL_STATE = 8'h02,
        CGC_SEL_GCTL  = 8'h04,
        CGC_SEL_ACCL  = 8'h08,
        CGC_SEL_ACCM  = 8'h10,
        CGC_SEL_ACCH  = 8'h20,
        CGC_SEL_AVG   = 8'h40
    } cgc_sel_e;

    // charger control word two
    typedef struct packed {
        logic [2:0]        test_select;
        logic [4:0]        offset_trim;
        logic signed [3:0] float_voltage_tweak;
        logic [3:0]        gain_trim;
    } cgc_chg_ctrl_s;

    // fuel gauge control word one
    typedef struct packed {
        logic [1:0] integ_cap;
        logic [1:0] bias_current;
        logic [2:0] sample_rate;
        logic       input_filter_on;
        logic [1:0] dac_scale;
        logic       chop_invert;
        logic       input_reroute;
        logic       mute;
        logic       reload_avg;
        logic       clear_acc;
        logic       enable;
    } cgc_gauge_ctrl_s;

    // charger state word
    typedef struct packed {
        logic [7:0] reserved_hi;
        logic       reserved_7;
        logic       die_heat_flag;
        logic       pack_hot_flag;
        logic       pack_temp_good_flag;
        logic       pack_cold_flag;
        logic       charge_done_flag;
        logic       voltage_loop_flag;
        logic       current_loop_flag;
    } cgc_chg_state_s;

endpackage
`default_nettype wire

// ### cgc_regs.sv
// Notes on behaviour
// - test selector: zero routes nothing, one to six pick, seven reserved
// - offset trim resets to 0xf, gain trim to 0x7; test only
// - float voltage tweak held as four-bit two's complement value
// - die heat flag reads one while die is too hot
// - pack hot flag reads one when thermistor below half supply
// - pack temp good flag reads one between half and seven eighths
// - pack cold flag reads one above seven eighths of supply
// - charge done flag reads one below ten percent current, charger on
// - voltage loop flag reads one in constant voltage regulation
// - current loop flag reads one in constant current regulation
// - integrator capacitor field 1/2/4/8 pF, resets to code three
// - bias current field 2/1/0.5/0.25 uA, resets to code one
// - sample rate: zero automatic, one to seven double from 18 kHz
// - input filter bit enables low-pass filter before integrator
// - dac scale field quarter to double bias, resets to code two
// - chop bit inverts converter inputs and outputs when one
// - input reroute bit stored and read back, no effect
// - mute bit ties converter input voltage to zero
// - reload copies low accumulator word to average; clear zeroes accumulator
// - enable zero: analog off, accumulator still writable by software
// - accumulator adds converter charge each sample, read as two 16-bit words and one 8-bit word
`timescale 1ns/1ps
`default_nettype none
module cgc_regs
    import cgc_pkg::*;
(
    input  wire logic                  pclk,            // bus clock
    input  wire logic                  presetn,         // async reset
    input  wire logic                  psel,            // apb select
    input  wire logic                  penable,         // apb enable
    input  wire logic                  pwrite,          // apb direction
    input  wire logic [31:0]           paddr,           // apb byte address
    input  wire logic [31:0]           pwdata,          // apb write data
    output logic      [31:0]           prdata,          // apb read data
    output logic                       pready,          // apb ready
    output logic                       pslverr,         // unmapped access
    input  wire logic                  die_hot_in,      // die over limit
    input  wire logic                  therm_below_half, // thermistor < 1/2
    input  wire logic                  therm_above_7_8, // thermistor > 7/8
    input  wire logic                  current_low_in,  // current < 10 %
    input  wire logic                  cv_regulating,   // voltage loop
    input  wire logic                  cc_regulating,   // current loop
    input  wire logic                  charger_on,      // charger enabled
    input  wire logic                  sample_tick,     // converter sample
    input  wire logic signed [15:0]    charge_value,    // converter charge
    output cgc_chg_ctrl_s              charger_ctrl,    // charger analog ctl
    output cgc_gauge_ctrl_s            gauge_ctrl,      // gauge analog ctl
    output logic                       testbus_route,   // test pin routing
    output logic                       filter_bypass,   // filter bypassed
    output logic                       converter_on,    // gauge analog on
    output logic                       input_grounded   // converter muted
);

    // bus phase decode
    logic                   setup_phase;
    logic                   wr_take;
    cgc_sel_e               cur_sel;
    logic [15:0]            wdata16;
    cgc_gauge_ctrl_s        wr_gauge;
    logic                   ctl_wr;
    logic                   gctl_wr;
    logic                   acc_wr_low;
    logic                   acc_wr_mid;
    logic                   acc_wr_high;

    // synchronised analog levels
    logic [CGC_SYNC_W-1:0]  async_in;
    logic [CGC_SYNC_W-1:0]  sync_a;
    logic [CGC_SYNC_W-1:0]  sync_b;
    logic                   tick_d;
    logic                   tick_rise;
    logic signed [15:0]     sample_hold;
    logic                   add_pending;

    // state registers
    cgc_chg_state_s         chg_state;
    logic [CGC_ACC_W-1:0]   charge_accumulator;
    logic [15:0]            charge_average;
    logic                   clear_pulse;
    logic                   reload_pulse;

    // map a byte address to a one-hot register select
    function automatic cgc_sel_e sel_of(input logic [31:0] addr);
        logic [CGC_DEC_BITS-1:0] a;
        a = addr[CGC_DEC_BITS-1:0];
        if (a == {CGC_IDX_CHG_CTRL2[CGC_DEC_BITS-3:0], 2'b00}) begin
            sel_of = CGC_SEL_CTRL2;
        end else if (a == {CGC_IDX_CHG_STATE[CGC_DEC_BITS-3:0], 2'b00}) begin
            sel_of = CGC_SEL_STATE;
        end else if (a == {CGC_IDX_GAUGE_CTRL1[CGC_DEC_BITS-3:0], 2'b00}) begin
            sel_of = CGC_SEL_GCTL;
        end else if (a == {CGC_IDX_ACC_LOW[CGC_DEC_BITS-3:0], 2'b00}) begin
            sel_of = CGC_SEL_ACCL;
        end else if (a == {CGC_IDX_ACC_MID[CGC_DEC_BITS-3:0], 2'b00}) begin
            sel_of = CGC_SEL_ACCM;
        end else if (a == {CGC_IDX_ACC_HIGH[CGC_DEC_BITS-3:0], 2'b00}) begin
            sel_of = CGC_SEL_ACCH;
        end else if (a == {CGC_IDX_ACC_AVG[CGC_DEC_BITS-3:0], 2'b00}) begin
            sel_of = CGC_SEL_AVG;
        end else begin
            sel_of = CGC_SEL_NONE;
        end
    endfunction

    // bus phases; write lands on the edge where pready is seen high
    assign setup_phase = psel & ~penable;
    assign wr_take     = psel & penable & pready & pwrite;
    assign cur_sel     = sel_of(paddr);
    assign wdata16     = pwdata[15:0];
    assign wr_gauge    = cgc_gauge_ctrl_s'(wdata16);

    // write strobes, one per writable word
    assign ctl_wr      = wr_take & (cur_sel == CGC_SEL_CTRL2);
    assign gctl_wr     = wr_take & (cur_sel == CGC_SEL_GCTL);
    assign acc_wr_low  = wr_take & ~gauge_ctrl.enable &
                         (cur_sel == CGC_SEL_ACCL);
    assign acc_wr_mid  = wr_take & ~gauge_ctrl.enable &
                         (cur_sel == CGC_SEL_ACCM);
    assign acc_wr_high = wr_take & ~gauge_ctrl.enable &
                         (cur_sel == CGC_SEL_ACCH);

    // one wait-free access cycle: pready high in every access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup_phase;
        end
    end

    // unmapped address answers with an error, also writes to read-only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            pslverr <= (cur_sel == CGC_SEL_NONE) |
                       (pwrite & ((cur_sel == CGC_SEL_STATE) |
                                  (cur_sel == CGC_SEL_AVG)));
        end else begin
            pslverr <= 1'b0;
        end
    end

    // read data captured in the setup cycle, upper bits zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            case (cur_sel)
                CGC_SEL_CTRL2: begin
                    prdata <= {16'h0000, charger_ctrl};
                end
                CGC_SEL_STATE: begin
                    prdata <= {16'h0000, 9'h000, chg_state[6:0]};
                end
                CGC_SEL_GCTL: begin
                    prdata <= {16'h0000, gauge_ctrl};
                end
                CGC_SEL_ACCL: begin
                    prdata <= {16'h0000, charge_accumulator[15:0]};
                end
                CGC_SEL_ACCM: begin
                    prdata <= {16'h0000, charge_accumulator[31:16]};
                end
                CGC_SEL_ACCH: begin
                    prdata <= {24'h000000,
                               charge_accumulator[CGC_ACC_W-1:32]};
                end
                CGC_SEL_AVG: begin
                    prdata <= {16'h0000, charge_average};
                end
                default: begin
                    prdata <= 32'h0000_0000;
                end
            endcase
        end else begin
            prdata <= 32'h0000_0000;
        end
    end

    // charger control word two
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            charger_ctrl <= cgc_chg_ctrl_s'(CGC_RST_CHG_CTRL2);
        end else if (ctl_wr) begin
            charger_ctrl <= cgc_chg_ctrl_s'(wdata16);
        end
    end

    // gauge control word one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gauge_ctrl <= cgc_gauge_ctrl_s'(CGC_RST_GAUGE_CTRL1);
        end else if (gctl_wr) begin
            gauge_ctrl <= wr_gauge;
        end
    end

    // one-cycle clear action for each written one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clear_pulse <= 1'b0;
        end else begin
            clear_pulse <= gctl_wr & wr_gauge.clear_acc;
        end
    end

    // one-cycle reload action for each written one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_pulse <= 1'b0;
        end else begin
            reload_pulse <= gctl_wr & wr_gauge.reload_avg;
        end
    end

    // test pin routing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            testbus_route <= 1'b0;
        end else begin
            // route only codes one to six
            testbus_route <= (charger_ctrl.test_select != CGC_TEST_NONE) &&
                             (charger_ctrl.test_select != CGC_TEST_RESERVED);
        end
    end

    // filter bypass, inverse of the filter bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filter_bypass <= 1'b1;
        end else begin
            filter_bypass <= ~gauge_ctrl.input_filter_on;
        end
    end

    // gauge analog power
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converter_on <= 1'b0;
        end else begin
            converter_on <= gauge_ctrl.enable;
        end
    end

    // converter input muting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_grounded <= 1'b0;
        end else begin
            input_grounded <= gauge_ctrl.mute;
        end
    end

    // analog levels gathered for the synchronisers
    assign async_in = {sample_tick, cc_regulating, cv_regulating,
                       current_low_in, therm_above_7_8, therm_below_half,
                       die_hot_in};

    // two flip-flop synchronisers
    genvar gi;
    generate
        for (gi = 0; gi < CGC_SYNC_W; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                end else begin
                    sync_a[gi] <= async_in[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate

    // sample edge taken from the second stage only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_d <= 1'b0;
        end else begin
            tick_d <= sync_b[6];
        end
    end
    assign tick_rise = sync_b[6] & ~tick_d;

    // converter value held when the tick arrives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_hold <= 16'sh0000;
        end else if (tick_rise) begin
            sample_hold <= charge_value;
        end
    end

    // add one cycle later, from the held value, keeping the adder off pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            add_pending <= 1'b0;
        end else begin
            add_pending <= tick_rise;
        end
    end

    // charger state flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chg_state <= '0;
        end else begin
            chg_state.reserved_hi         <= 8'h00;
            chg_state.reserved_7          <= 1'b0;
            chg_state.die_heat_flag       <= sync_b[0];
            chg_state.pack_hot_flag       <= sync_b[1];
            chg_state.pack_temp_good_flag <= ~sync_b[1] & ~sync_b[2];
            chg_state.pack_cold_flag      <= sync_b[2] & ~sync_b[1];
            chg_state.charge_done_flag    <= sync_b[3] & charger_on;
            chg_state.voltage_loop_flag   <= sync_b[4] & charger_on;
            chg_state.current_loop_flag   <= sync_b[5] & charger_on;
        end
    end

    // charge accumulator: clear, software write, then sample add
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            charge_accumulator <= '0;
        end else if (clear_pulse) begin
            charge_accumulator <= '0;
        end else if (acc_wr_low) begin
            charge_accumulator[15:0] <= wdata16;
        end else if (acc_wr_mid) begin
            charge_accumulator[31:16] <= wdata16;
        end else if (acc_wr_high) begin
            charge_accumulator[CGC_ACC_W-1:32] <= wdata16[CGC_HIGH_W-1:0];
        end else if (add_pending && gauge_ctrl.enable) begin
            charge_accumulator <= charge_accumulator +
                CGC_ACC_W'({{(CGC_ACC_W-16){sample_hold[15]}},
                            sample_hold});
        end
    end

    // averaged charge reload
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            charge_average <= 16'h0000;
        end else if (reload_pulse) begin
            charge_average <= charge_accumulator[15:0];
        end
    end

endmodule
`default_nettype wire

// ### cgc_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cgc_regs_sva
    import cgc_pkg::*;
(
    input wire logic            pclk,           // bus clock
    input wire logic            presetn,        // async reset
    input wire logic            psel,           // apb select
    input wire logic            penable,        // apb enable
    input wire logic            pwrite,         // apb direction
    input wire logic [31:0]     paddr,          // apb address
    input wire logic [31:0]     pwdata,         // apb write data
    input wire logic [31:0]     prdata,         // apb read data
    input wire logic            pready,         // apb ready
    input wire logic            pslverr,        // apb error
    input wire cgc_chg_ctrl_s   charger_ctrl,   // charger image
    input wire cgc_gauge_ctrl_s gauge_ctrl,     // gauge image
    input wire logic            testbus_route,  // test routing
    input wire logic            filter_bypass,  // filter bypassed
    input wire logic            converter_on,   // gauge on
    input wire logic            input_grounded  // gauge muted
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // decoded byte addresses, low twelve bits
    localparam logic [11:0] SV_CTL = 12'(CGC_IDX_CHG_CTRL2 << 2);
    localparam logic [11:0] SV_ST  = 12'(CGC_IDX_CHG_STATE << 2);
    localparam logic [11:0] SV_GC  = 12'(CGC_IDX_GAUGE_CTRL1 << 2);

    // completing edges of writes and status reads
    logic wr_hit;
    logic rd_st;
    assign wr_hit = psel && penable && pready && pwrite;
    assign rd_st  = pready && !pwrite && !pslverr && paddr[11:0] == SV_ST;

    property p_ready;
        psel && !penable |=> pready && penable;
    endproperty
    property p_err_ready;
        pslverr |-> pready && psel;
    endproperty
    property p_ctl_wr;
        wr_hit && paddr[11:0] == SV_CTL |=>
            charger_ctrl == $past(pwdata[15:0]);
    endproperty
    property p_gc_wr;
        wr_hit && paddr[11:0] == SV_GC |=>
            gauge_ctrl == $past(pwdata[15:0]);
    endproperty
    property p_st_ro;
        wr_hit && paddr[11:0] == SV_ST |-> pslverr;
    endproperty
    property p_st_rsv;
        rd_st |-> prdata[31:7] == 25'h0;
    endproperty
    property p_window;
        rd_st |-> prdata[4] == !(prdata[5] || prdata[3]) &&
                  !(prdata[5] && prdata[3]);
    endproperty
    property p_route;
        $stable(charger_ctrl.test_select) |->
            testbus_route == (charger_ctrl.test_select inside {[3'h1:3'h6]});
    endproperty
    property p_filter;
        $stable(gauge_ctrl.input_filter_on) [*2] |->
            filter_bypass == !gauge_ctrl.input_filter_on;
    endproperty
    property p_power;
        $stable(gauge_ctrl.enable) |-> converter_on == gauge_ctrl.enable;
    endproperty
    property p_mute;
        $rose(gauge_ctrl.mute) |-> ##[0:1] input_grounded;
    endproperty

    a_ready: assert property (p_ready) else $error("no ready");
    a_err_ready: assert property (p_err_ready) else $error("stray error");
    a_ctl_wr: assert property (p_ctl_wr) else $error("ctrl lost");
    a_gc_wr: assert property (p_gc_wr) else $error("gauge lost");
    a_st_ro: assert property (p_st_ro) else $error("state written");
    a_st_rsv: assert property (p_st_rsv) else $error("reserved set");
    a_window: assert property (p_window) else $error("temp window");
    a_route: assert property (p_route) else $error("routing bad");
    a_filter: assert property (p_filter) else $error("filter bad");
    a_power: assert property (p_power) else $error("enable bad");
    a_mute: assert property (p_mute) else $error("mute late");

    c_ctl_wr: cover property (wr_hit && paddr[11:0] == SV_CTL);
    c_hot: cover property (rd_st && prdata[5]);
    c_cold: cover property (rd_st && prdata[3]);
    c_err: cover property (pslverr);
endmodule
bind cgc_regs cgc_regs_sva cgc_regs_sva_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .charger_ctrl(charger_ctrl),
    .gauge_ctrl(gauge_ctrl), .testbus_route(testbus_route),
    .filter_bypass(filter_bypass), .converter_on(converter_on),
    .input_grounded(input_grounded));
`default_nettype wire

// ### cgc_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cgc_regs_tb
    import cgc_pkg::*;
    ;
    localparam logic [31:0] A_CTL = CGC_IDX_CHG_CTRL2 << 2;
    localparam logic [31:0] A_ST = CGC_IDX_CHG_STATE << 2;
    localparam logic [31:0] A_GC = CGC_IDX_GAUGE_CTRL1 << 2;
    localparam logic [31:0] A_AL = CGC_IDX_ACC_LOW << 2;
    localparam logic [31:0] A_AM = CGC_IDX_ACC_MID << 2;
    localparam logic [31:0] A_AH = CGC_IDX_ACC_HIGH << 2;
    localparam logic [31:0] A_AV = CGC_IDX_ACC_AVG << 2;
    localparam logic [31:0] A_BAD = 32'h00000a00;
    logic            pclk = 1'b0;
    logic            presetn = 1'b0;
    logic            psel = 1'b0;
    logic            penable = 1'b0;
    logic            pwrite = 1'b0;
    logic [31:0]     paddr = 32'h0;
    logic [31:0]     pwdata = 32'h0;
    logic [6:0]      stin = 7'h0;   // die,below,above,low,cv,cc,on
    logic            tick = 1'b0;
    logic [15:0]     qv = 16'h0;
    logic [31:0]     prdata;
    logic [31:0]     rv;
    logic            pready, pslverr, er, route, fbyp, conv_on, grounded;
    cgc_chg_ctrl_s   cctl;
    cgc_gauge_ctrl_s gctl;
    int              n_fail = 0;
    int              cmp_count = 0;

    // 25 MHz bus clock
    always #20 pclk = ~pclk;

    cgc_regs cgc_regs_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .die_hot_in(stin[6]),
        .therm_below_half(stin[5]), .therm_above_7_8(stin[4]),
        .current_low_in(stin[3]), .cv_regulating(stin[2]),
        .cc_regulating(stin[1]), .charger_on(stin[0]),
        .sample_tick(tick), .charge_value(qv), .charger_ctrl(cctl),
        .gauge_ctrl(gctl), .testbus_route(route), .filter_bypass(fbyp),
        .converter_on(conv_on), .input_grounded(grounded));

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer, held until ready is seen
    task automatic apb(input logic wr, input logic [31:0] a, d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_fail++;
            end_of_test();
        end
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, d, input logic e);
        apb(1'b1, a, d);
        chk({31'h0, er}, {31'h0, e});
    endtask

    task automatic rdc(input logic [31:0] a, exp, input logic e);
        apb(1'b0, a, 32'h0);
        chk({rv[31:1], rv[0] ^ (er !== e)}, exp);
    endtask

    // one converter sample of value v
    task automatic sample(input logic [15:0] v);
        qv <= v;
        @(posedge pclk);
        tick <= 1'b1;
        repeat (2) @(posedge pclk);
        tick <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask

    function automatic logic [31:0] st_exp(input logic [6:0] s);
        logic die, bl, ab, lo, cv, cc, on;
        {die, bl, ab, lo, cv, cc, on} = s;
        return {25'h0, die, bl, !bl && !ab, ab && !bl,
                lo && on, cv && on, cc && on};
    endfunction

    // watchdog
    initial begin
        repeat (5000) @(posedge pclk);
        n_fail++;
        end_of_test();
    end

    initial begin
        logic [31:0] d;
        logic [39:0] sum;
        logic [15:0] v;
        d = $urandom(81);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk({16'h0, cctl}, {16'h0, 3'h0, 5'h0f, 4'h0, 4'h7});
        chk({31'h0, fbyp}, 32'h1);
        rdc(A_CTL, {16'h0, 3'h0, 5'h0f, 4'h0, 4'h7}, 1'b0);
        d = {16'h0, 2'h3, 2'h1, 3'h4, 1'b0, 2'h2, 6'h0};
        rdc(A_GC, d, 1'b0);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            d = $urandom;
            d[15:13] = i[2:0];
            wr(A_CTL, d, 1'b0);
            rdc(A_CTL, {16'h0, d[15:0]}, 1'b0);
            chk({31'h0, route}, {31'h0, i inside {[1:6]}});
        end
        $display("test charger control done");
        for (int i = 0; i < 12; i++) begin
            d = $urandom;
            wr(A_GC, d, 1'b0);
            rdc(A_GC, {16'h0, d[15:0]}, 1'b0);
            chk({29'h0, fbyp, conv_on, grounded},
                {29'h0, !d[8], d[0], d[3]});
            chk({31'h0, gctl.chop_invert}, {31'h0, d[5]});
        end
        $display("test gauge control done");
        for (int i = 0; i < 16; i++) begin
            d = $urandom;
            stin <= d[6:0];
            repeat (5) @(posedge pclk);
            rdc(A_ST, st_exp(d[6:0]), 1'b0);
        end
        wr(A_ST, 32'hffff, 1'b1);
        rdc(A_ST, st_exp(d[6:0]), 1'b0);
        rdc(A_BAD, 32'h0, 1'b1);
        $display("test status done");
        wr(A_GC, 32'h0, 1'b0);
        wr(A_AL, 32'h1234, 1'b0);
        wr(A_AH, 32'h009a, 1'b0);
        rdc(A_AL, 32'h1234, 1'b0);
        rdc(A_AH, 32'h009a, 1'b0);
        wr(A_GC, 32'h3, 1'b0);
        wr(A_GC, 32'h1, 1'b0);
        rdc(A_AL, 32'h0, 1'b0);
        sum = 40'h0;
        for (int k = 0; k < 3; k++) begin
            v = 16'($urandom) | (k == 0 ? 16'h8000 : 16'h0);
            sample(v);
            sum = sum + {{24{v[15]}}, v};
        end
        rdc(A_AL, {16'h0, sum[15:0]}, 1'b0);
        rdc(A_AM, {16'h0, sum[31:16]}, 1'b0);
        rdc(A_AH, {24'h0, sum[39:32]}, 1'b0);
        wr(A_GC, 32'h5, 1'b0);
        rdc(A_AV, {16'h0, sum[15:0]}, 1'b0);
        sample(16'h0101);
        rdc(A_AV, {16'h0, sum[15:0]}, 1'b0);
        wr(A_AV, 32'h0, 1'b1);
        $display("test accumulator done");
        end_of_test();
    end
endmodule
`default_nettype wire
